// [shared/icu_pkg.sv]
package icu_pkg;
    // register byte addresses on the axi4-lite bus
    localparam logic [5:0] ADDR_NMI_PEND = 6'h00;
    localparam logic [5:0] ADDR_NMI_CTRL = 6'h04;
    localparam logic [5:0] ADDR_VECTOR = 6'h08;
    localparam logic [5:0] ADDR_MASK_LO = 6'h0c;
    localparam logic [5:0] ADDR_MASK_HI = 6'h10;
    localparam logic [5:0] ADDR_RAW_LO = 6'h14;
    localparam logic [5:0] ADDR_RAW_HI = 6'h18;
    localparam logic [5:0] ADDR_PSW = 6'h1c;
    localparam logic [5:0] ADDR_TBASE = 6'h20;
    localparam logic [5:0] ADDR_TSP = 6'h24;
    // nonmaskable_trap_control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PIN_BIT = 1;
    localparam int CTRL_LOCK_BIT = 2;
    // processor_status_word fields
    localparam int PSW_E_BIT = 9;
    localparam int PSW_I_BIT = 11;
    localparam logic [15:0] PSW_RESET = 16'h0200;
    localparam logic [7:0] MASK_RESET = 8'hff;
    // 21-bit pointers: top five bits and bit 0 are always zero
    localparam logic [20:0] PTR_KEEP = 21'h00fffe;
    localparam logic [4:0] VEC_BASE = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [15:0] psw;
        logic [20:0] tsp;
    } core_state_s;
endpackage : icu_pkg

// [core/interrupt_control_unit.sv]
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module interrupt_control_unit #(
    parameter int NUM_REQ = 16
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    // request pins
    input wire logic I_NMI_PIN_B,
    input wire logic [NUM_REQ-1:0] I_IRQ,
    // core side
    input wire logic I_ACK,
    input wire logic I_NMI_TAKEN,
    input wire logic I_RETURN,
    input wire logic [15:0] I_RESTORE_PSW,
    input wire logic I_SET_E,
    input wire logic I_CLR_E,
    // axi4-lite slave
    input wire logic [5:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [5:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // to core
    output logic O_NMI_REQ,
    output logic O_IRQ_REQ,
    output logic [7:0] O_VECTOR,
    output icu_pkg::core_state_s O_CORE,
    output logic [20:0] O_TBASE
);
    import icu_pkg::*;

    if (NUM_REQ != 16) begin : g_num_req_check
        $error("NUM_REQ must be 16");
    end

    logic nmi_en, nmi_lock, nmi_pend, pin_d;
    logic [15:0] mask, psw;
    logic [20:0] tbase, tsp;
    logic [7:0] vector;
    logic aw_held, w_held;
    logic [5:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // nmi edge detect: pin is synchronous to the clock
    wire nmi_fall = pin_d & ~I_NMI_PIN_B;
    wire nmi_armed = nmi_lock | nmi_en;
    wire nmi_trap = nmi_fall & nmi_armed;

    // priority encode, 15 highest
    wire [15:0] active = I_IRQ & mask;
    logic [3:0] win;
    always_comb begin
        win = 4'h0;
        for (int k = 0; k < 16; k++) begin
            if (active[k]) win = 4'(k);
        end
    end
    wire any_active = |active;
    wire irq_ok = psw[PSW_E_BIT] & psw[PSW_I_BIT];
    wire [7:0] next_vector = {3'h0, VEC_BASE | {1'b0, win}};

    // bus write decode
    // writes apply the held beat: the master may change wdata once it is taken
    wire wr_go = aw_held & w_held & ~O_BVALID;
    wire wr_hit = (aw_addr == ADDR_NMI_CTRL) | (aw_addr == ADDR_MASK_LO) | (aw_addr == ADDR_MASK_HI) |
        (aw_addr == ADDR_PSW) | (aw_addr == ADDR_TBASE) | (aw_addr == ADDR_TSP) |
        (aw_addr == ADDR_NMI_PEND) | (aw_addr == ADDR_VECTOR) | (aw_addr == ADDR_RAW_LO) |
        (aw_addr == ADDR_RAW_HI);
    wire wr_ctrl = wr_go & (aw_addr == ADDR_NMI_CTRL) & w_strb[0];
    wire wr_mlo = wr_go & (aw_addr == ADDR_MASK_LO) & w_strb[0];
    wire wr_mhi = wr_go & (aw_addr == ADDR_MASK_HI) & w_strb[0];
    wire wr_psw = wr_go & (aw_addr == ADDR_PSW) & (&w_strb[1:0]);
    wire wr_tbase = wr_go & (aw_addr == ADDR_TBASE) & (&w_strb[2:0]);
    wire wr_tsp = wr_go & (aw_addr == ADDR_TSP) & (&w_strb[2:0]);

    // bus read decode
    wire rd_go = I_ARVALID & O_ARREADY;
    wire [7:0] ctrl_rd = {5'h00, nmi_lock, I_NMI_PIN_B, nmi_en};
    logic [31:0] rd_mux;
    logic rd_err;
    always_comb begin
        rd_err = 1'b0;
        case (I_ARADDR)
            ADDR_NMI_PEND: rd_mux = {31'h0, nmi_pend};
            ADDR_NMI_CTRL: rd_mux = {24'h0, ctrl_rd};
            ADDR_VECTOR: rd_mux = {24'h0, vector};
            ADDR_MASK_LO: rd_mux = {24'h0, mask[7:0]};
            ADDR_MASK_HI: rd_mux = {24'h0, mask[15:8]};
            ADDR_RAW_LO: rd_mux = {24'h0, I_IRQ[7:0]};
            ADDR_RAW_HI: rd_mux = {24'h0, I_IRQ[15:8]};
            ADDR_PSW: rd_mux = {16'h0, psw};
            ADDR_TBASE: rd_mux = {11'h0, tbase};
            ADDR_TSP: rd_mux = {11'h0, tsp};
            default: begin
                rd_mux = 32'h0;
                rd_err = 1'b1;
            end
        endcase
    end
    wire rd_pend = rd_go & (I_ARADDR == ADDR_NMI_PEND);

    // psw next value: core events outrank bus writes
    logic [15:0] next_psw;
    always_comb begin
        next_psw = psw;
        if (wr_psw) next_psw = w_data[15:0];
        if (I_SET_E) next_psw[PSW_E_BIT] = 1'b1;
        if (I_CLR_E) next_psw[PSW_E_BIT] = 1'b0;
        if (I_ACK | I_NMI_TAKEN) next_psw[PSW_I_BIT] = 1'b0;
        if (I_RETURN) next_psw = I_RESTORE_PSW;
    end

    // stack pointer steps one psw word down on entry, up on return
    logic [20:0] next_tsp;
    always_comb begin
        next_tsp = tsp;
        if (wr_tsp) next_tsp = w_data[20:0] & PTR_KEEP;
        if (I_ACK | I_NMI_TAKEN) next_tsp = (tsp - 21'h2) & PTR_KEEP;
        else if (I_RETURN) next_tsp = (tsp + 21'h2) & PTR_KEEP;
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            nmi_en <= 1'b0;
            nmi_lock <= 1'b0;
            nmi_pend <= 1'b0;
            pin_d <= 1'b1;
        end else if (I_CE) begin
            pin_d <= I_NMI_PIN_B;
            // lock is sticky: only reset clears it
            if (wr_ctrl & w_data[CTRL_LOCK_BIT]) nmi_lock <= 1'b1;
            if (nmi_trap & ~nmi_lock) nmi_en <= 1'b0;
            else if (wr_ctrl) nmi_en <= w_data[CTRL_EN_BIT];
            // set wins over read clear
            if (nmi_trap) nmi_pend <= 1'b1;
            else if (rd_pend) nmi_pend <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mask <= {MASK_RESET, MASK_RESET};
            psw <= PSW_RESET;
            tbase <= 21'h0;
            tsp <= 21'h0;
            vector <= 8'h0;
        end else if (I_CE) begin
            if (wr_mlo) mask[7:0] <= w_data[7:0];
            if (wr_mhi) mask[15:8] <= w_data[7:0];
            psw <= next_psw;
            if (wr_tbase) tbase <= w_data[20:0] & PTR_KEEP;
            tsp <= next_tsp;
            // vector frozen during acknowledge so the core reads a stable value
            if (!I_ACK && any_active) vector <= next_vector;
        end
    end

    // outputs to core
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_NMI_REQ <= 1'b0;
            O_IRQ_REQ <= 1'b0;
            O_VECTOR <= 8'h0;
            O_CORE <= '0;
            O_TBASE <= 21'h0;
        end else if (I_CE) begin
            O_NMI_REQ <= nmi_trap;
            O_IRQ_REQ <= any_active & irq_ok & ~I_ACK;
            O_VECTOR <= I_ACK ? vector : next_vector;
            O_CORE <= '{psw: next_psw, tsp: next_tsp};
            O_TBASE <= wr_tbase ? (w_data[20:0] & PTR_KEEP) : tbase;
        end
    end

    // axi4-lite write channel: address and data taken in either order
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 6'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            O_BVALID <= 1'b0;
            O_BRESP <= RESP_OKAY;
        end else if (I_CE) begin
            // ready never waits for valid, so a waiting master cannot stall a channel
            O_AWREADY <= ~aw_held;
            O_WREADY <= ~w_held;
            if (I_AWVALID & O_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= I_AWADDR;
                O_AWREADY <= 1'b0;
            end
            if (I_WVALID & O_WREADY) begin
                w_held <= 1'b1;
                w_data <= I_WDATA;
                w_strb <= I_WSTRB;
                O_WREADY <= 1'b0;
            end
            if (wr_go) begin
                O_BVALID <= 1'b1;
                O_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (O_BVALID & I_BREADY) begin
                O_BVALID <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                O_AWREADY <= 1'b1;
                O_WREADY <= 1'b1;
            end
        end
    end

    // axi4-lite read channel
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_ARREADY <= 1'b1;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0;
            O_RRESP <= RESP_OKAY;
        end else if (I_CE) begin
            if (rd_go) begin
                O_ARREADY <= 1'b0;
                O_RVALID <= 1'b1;
                O_RDATA <= rd_mux;
                O_RRESP <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (O_RVALID & I_RREADY) begin
                O_RVALID <= 1'b0;
                O_ARREADY <= 1'b1;
            end
        end
    end

    // assertions
    sequence fall_s;
        pin_d && !I_NMI_PIN_B;
    endsequence
    // trap entry: acknowledge or nmi taken with no return in the same cycle
    sequence entry_s;
        I_CE && (I_ACK || I_NMI_TAKEN) && !I_RETURN;
    endsequence
    sequence return_s;
        I_CE && I_RETURN && !I_ACK && !I_NMI_TAKEN;
    endsequence
    sequence top_req_s;
        I_CE && !I_ACK && I_IRQ[15] && mask[15];
    endsequence
    one_shot_trap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (I_CE && nmi_en && !nmi_lock) and fall_s |=> O_NMI_REQ && !nmi_en)
        else $error("one-shot trap missing");
    no_arm_no_trap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && !nmi_en && !nmi_lock |=> !O_NMI_REQ)
        else $error("trap while disarmed");
    lock_sticky_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        nmi_lock |=> nmi_lock)
        else $error("lock bit dropped");
    lock_keeps_en_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && nmi_lock && nmi_en && !wr_ctrl |=> nmi_en)
        else $error("enable cleared under lock");
    pin_read_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        rd_go && I_ARADDR == ADDR_NMI_CTRL && I_CE |=> O_RDATA[CTRL_PIN_BIT] == $past(I_NMI_PIN_B))
        else $error("pin bit wrong");
    vector_range_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        vector != 8'h0 |-> vector[7:4] == 4'h1)
        else $error("vector out of range");
    vector_stable_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_ACK |=> $stable(vector))
        else $error("vector moved in ack");
    irq_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && !(psw[PSW_E_BIT] && psw[PSW_I_BIT]) |=> !O_IRQ_REQ)
        else $error("irq while disabled");
    entry_clears_i_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && I_ACK && !I_RETURN |=> !psw[PSW_I_BIT])
        else $error("global enable kept");
    ptr_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        tsp[20:16] == 5'h0 && !tsp[0] && tbase[20:16] == 5'h0 && !tbase[0])
        else $error("pointer fixed bits set");
    pend_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && nmi_trap |=> nmi_pend)
        else $error("pending flag lost");

    // nmi arming and pending flag
    lock_trap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (I_CE && nmi_lock) and fall_s |=> O_NMI_REQ)
        else $error("locked trap missing");
    pend_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && rd_pend && !nmi_trap |=> !nmi_pend)
        else $error("pending flag not cleared");

    // maskable requests and vector
    top_wins_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        top_req_s |=> vector == 8'h1f)
        else $error("top request lost priority");
    vec_field_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        vector[7:5] == 3'h0)
        else $error("vector upper bits set");
    masked_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && (I_IRQ & mask) == 16'h0 |=> !O_IRQ_REQ)
        else $error("request without unmasked input");
    raw_read_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && rd_go && I_ARADDR == ADDR_RAW_HI |=> O_RDATA[7:0] == $past(I_IRQ[15:8]))
        else $error("raw status wrong");
    mask_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && wr_mlo |=> mask[7:0] == $past(w_data[7:0]))
        else $error("mask write lost");

    // core registers
    entry_step_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        entry_s |=> !psw[PSW_I_BIT] &&
            tsp == (($past(tsp) - 21'h2) & PTR_KEEP))
        else $error("entry step wrong");
    return_step_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        return_s |=> psw == $past(I_RESTORE_PSW) &&
            tsp == (($past(tsp) + 21'h2) & PTR_KEEP))
        else $error("return step wrong");
    set_enable_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && I_SET_E && !I_CLR_E && !I_RETURN |=> psw[PSW_E_BIT])
        else $error("local enable not set");
    clear_enable_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE && I_CLR_E && !I_RETURN |=> !psw[PSW_E_BIT])
        else $error("local enable not cleared");
    core_copy_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE |=> O_CORE.psw == psw && O_CORE.tsp == tsp)
        else $error("core copy stale");
    tbase_out_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_CE |=> O_TBASE == tbase)
        else $error("table base output stale");

    // bus answers stand until taken
    bvalid_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        O_BVALID && !I_BREADY |=> O_BVALID)
        else $error("write response dropped");
    rvalid_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped");
endmodule : interrupt_control_unit

// [verif/core_model.sv]
`timescale 1ns/10ps
module core_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // bench control
    input wire logic i_accept,
    input wire logic [3:0] i_delay,
    // from the unit
    input wire logic i_irq_req,
    input wire logic i_nmi_req,
    // to the unit
    output logic o_ack,
    output logic o_nmi_taken
);
    logic [3:0] wait_cnt;
    wire hit = i_accept && i_irq_req && !o_ack;
    // acknowledge once the request has stood i_delay+1 cycles
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_cnt <= 4'h0;
            o_ack <= 1'b0;
            o_nmi_taken <= 1'b0;
        end else begin
            o_nmi_taken <= i_nmi_req;
            o_ack <= hit && wait_cnt == i_delay;
            wait_cnt <= (hit && wait_cnt != i_delay) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : core_model

// [verif/interrupt_control_unit_tb_top.sv]
`timescale 1ns/10ps
module interrupt_control_unit_tb_top;
    import icu_pkg::*;
    logic clk, rst_b, pin_b, ret, set_e, clr_e, accept, ack, nmi_tk, ce;
    logic awv, wv, bready, arv, rready, awr, wr, bv, arr, rv, nmi_req, irq_req;
    logic [3:0] delay, strb;
    logic [15:0] irq, rest;
    logic [5:0] awa, ara;
    logic [31:0] wd, rd, d;
    logic [1:0] bresp, rresp;
    logic [7:0] vec;
    logic [20:0] tbase;
    core_state_s core;
    int num_errors = 0, tests_run = 0, cycles = 0, nmi_seen = 0;

    interrupt_control_unit interrupt_control_unit_i (.I_CLK(clk), .I_RST_B(rst_b), .I_CE(ce),
        .I_NMI_PIN_B(pin_b), .I_IRQ(irq), .I_ACK(ack), .I_NMI_TAKEN(nmi_tk), .I_RETURN(ret),
        .I_RESTORE_PSW(rest), .I_SET_E(set_e), .I_CLR_E(clr_e), .I_AWADDR(awa), .I_AWVALID(awv),
        .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(strb), .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(bresp),
        .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
        .O_RDATA(rd), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rready), .O_NMI_REQ(nmi_req),
        .O_IRQ_REQ(irq_req), .O_VECTOR(vec), .O_CORE(core), .O_TBASE(tbase));
    core_model core_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_accept(accept), .i_delay(delay),
        .i_irq_req(irq_req), .i_nmi_req(nmi_req), .o_ack(ack), .o_nmi_taken(nmi_tk));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (nmi_req === 1'b1) nmi_seen++;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    task close_out();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task wr_reg(input logic [5:0] a, input logic [31:0] v);
        @(posedge clk);
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        bready <= 1'b0;
        check("bresp", bresp, RESP_OKAY);
    endtask : wr_reg
    task rd_reg(input logic [5:0] a, input logic [1:0] er);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
        d = rd;
        check("rresp", rresp, er);
    endtask : rd_reg
    task rchk(input logic [5:0] a, input logic [31:0] exp);
        rd_reg(a, RESP_OKAY);
        check($sformatf("reg %h", a), d, exp);
    endtask : rchk
    task pulse(input int which);
        if (which == 0) set_e <= 1'b1; else if (which == 1) clr_e <= 1'b1; else ret <= 1'b1;
        @(posedge clk);
        {set_e, clr_e, ret} <= 3'h0;
        tick(3);
    endtask : pulse
    task nmi_fall();
        pin_b <= 1'b0;
        tick(4);
        pin_b <= 1'b1;
        tick(4);
    endtask : nmi_fall

    initial begin
        {rst_b, ret, set_e, clr_e, accept, awv, wv, bready, arv, rready} = 10'h0;
        pin_b = 1'b1; irq = 16'h0; rest = 16'h0; delay = 4'h4;
        ce = 1'b1; strb = 4'hf;
        awa = 6'h0; ara = 6'h0; wd = 32'h0;
        tick(2);
        rst_b <= 1'b1;
        rchk(ADDR_MASK_LO, 32'hff);
        rchk(ADDR_MASK_HI, 32'hff);
        rchk(ADDR_PSW, 32'h0200);
        rchk(ADDR_NMI_CTRL, 32'h2);
        rchk(ADDR_NMI_PEND, 32'h0);
        rd_reg(6'h3c, RESP_SLVERR);
        check("unmapped", d, 32'h0);
        $display("test reset done");
        strb <= 4'h0;
        wr_reg(ADDR_MASK_HI, 32'h0);
        strb <= 4'hf;
        rchk(ADDR_MASK_HI, 32'hff);
        wr_reg(ADDR_MASK_LO, 32'h0);
        irq <= 16'h8042;
        rchk(ADDR_RAW_LO, 32'h42);
        rchk(ADDR_RAW_HI, 32'h80);
        rchk(ADDR_MASK_LO, 32'h0);
        $display("test status done");
        wr_reg(ADDR_MASK_LO, 32'hff);
        wr_reg(ADDR_MASK_HI, 32'h7f);
        tick(3);
        check("irq_req", irq_req, 1'b0);
        check("vector", vec, 8'h16);
        rchk(ADDR_VECTOR, 32'h16);
        wr_reg(ADDR_PSW, 32'h0a00);
        wr_reg(ADDR_MASK_HI, 32'hff);
        tick(3);
        check("irq_req", irq_req, 1'b1);
        check("vector", vec, 8'h1f);
        pulse(1);
        check("irq_req", irq_req, 1'b0);
        rchk(ADDR_PSW, 32'h0800);
        pulse(0);
        check("irq_req", irq_req, 1'b1);
        $display("test priority done");
        wr_reg(ADDR_TSP, 32'hffffffff);
        rchk(ADDR_TSP, 32'h00fffe);
        wr_reg(ADDR_TSP, 32'he100);
        wr_reg(ADDR_TBASE, 32'hffffffff);
        rchk(ADDR_TBASE, 32'h00fffe);
        check("tbase", tbase, 21'h00fffe);
        accept <= 1'b1;
        tick(12);
        accept <= 1'b0;
        check("psw", core.psw, 16'h0200);
        check("tsp", core.tsp, 21'h0e0fe);
        check("irq_req", irq_req, 1'b0);
        check("vector", vec, 8'h1f);
        rest <= 16'h0a00;
        pulse(2);
        check("psw", core.psw, 16'h0a00);
        check("tsp", core.tsp, 21'h0e100);
        irq <= 16'h0;
        $display("test entry done");
        wr_reg(ADDR_NMI_CTRL, 32'h1);
        rchk(ADDR_NMI_CTRL, 32'h3);
        pin_b <= 1'b0;
        tick(4);
        rchk(ADDR_NMI_CTRL, 32'h0);
        pin_b <= 1'b1;
        tick(4);
        check("nmi count", nmi_seen, 1);
        check("tsp", core.tsp, 21'h0e0fe);
        rchk(ADDR_NMI_PEND, 32'h1);
        rchk(ADDR_NMI_PEND, 32'h0);
        nmi_fall();
        check("nmi count", nmi_seen, 1);
        wr_reg(ADDR_NMI_CTRL, 32'h4);
        nmi_fall();
        nmi_fall();
        check("nmi count", nmi_seen, 3);
        wr_reg(ADDR_NMI_CTRL, 32'h5);
        nmi_fall();
        rchk(ADDR_NMI_CTRL, 32'h7);
        check("nmi count", nmi_seen, 4);
        ce <= 1'b0;
        nmi_fall();
        ce <= 1'b1;
        tick(2);
        check("nmi count", nmi_seen, 4);
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        rchk(ADDR_NMI_CTRL, 32'h2);
        $display("test nmi done");
        close_out();
    end
endmodule : interrupt_control_unit_tb_top
